// File: hdl/hbp_top.sv
// Top of the six-input half-bridge PWM control with APB registers
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/10ps
module hbp_top (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // PWM pins, asynchronous
  input wire logic [5:0] i_pwm_in,
  // Detected role per bridge, same clock
  input wire logic [2:0] i_hs_active_det,
  // Delay measurements per bridge
  input wire hbp_pkg::hbp_meas_s [2:0] i_meas,
  // Gate commands
  output logic [2:0] o_hs_on,
  output logic [2:0] o_ls_on,
  output logic [2:0] o_hard_turn_off,
  output logic [2:0] o_passive_off,
  output logic [2:0] o_active_off,
  output logic [17:0] o_gate_charge_current_code,
  output logic [17:0] o_initial_precharge_code,
  output logic [2:0] o_delay_in_regulation_flag,
  output logic o_irq
);
  //////////////////////////////////////////////////////////////////
  // Declarations
  hbp_pkg::hbp_ctrl_s ctrl_r; // Global control
  hbp_pkg::hbp_win_s win_r; // Window lengths
  hbp_pkg::hbp_bridge_s [2:0] bridge_r; // Per-bridge settings
  logic [5:0] irq_stat_r; // Sticky events
  logic [5:0] irq_mask_r; // Event enables
  logic [5:0] sync1_r; // First sync stage
  logic [5:0] sync2_r; // Second sync stage
  logic [5:0] sync3_r; // Third sync stage
  logic [5:0] pwm_r; // Filtered PWM levels
  logic [5:0] agree; // Stages two and three agree
  logic [2:0] bridge_run; // Six-input PWM active
  logic [2:0] hs_active; // Active role is HS
  logic [2:0] reg_active; // Regulation tracking enabled
  logic [2:0] in_reg; // Regulation flags
  logic [2:0] in_reg_d_r; // Delayed flags
  logic [2:0] hs_on, ls_on, hard, ign; // Sequencer outputs
  logic [5:0] irq_set; // Events this cycle
  logic wr_setup, rd_setup, wr_acc; // Bus phases
  logic [31:0] rd_data; // Decoded read data
  logic addr_ok; // Mapped address
  logic adapt_sel; // ADAPTIVE_GATE_CTRL_SEL uses regulation
  //////////////////////////////////////////////////////////////////
  // APB phase decode
  always_comb begin
    wr_setup = i_psel & ~i_penable & i_pwrite;
    rd_setup = i_psel & ~i_penable & ~i_pwrite;
    wr_acc = i_psel & i_penable & i_pwrite & o_pready;
  end
  //////////////////////////////////////////////////////////////////
  // Read mux and address check
  always_comb begin
    rd_data = 32'h0000_0000;
    addr_ok = 1'b1;
    if (i_paddr == hbp_pkg::ADDR_CTRL) begin
      rd_data[4:0] = ctrl_r;
    end else if (i_paddr == hbp_pkg::ADDR_WIN) begin
      rd_data[23:0] = win_r;
    end else if (i_paddr == hbp_pkg::ADDR_BRIDGE0) begin
      rd_data[30:0] = bridge_r[0];
    end else if (i_paddr == hbp_pkg::ADDR_BRIDGE0 + hbp_pkg::ADDR_BRIDGE_STEP) begin
      rd_data[30:0] = bridge_r[1];
    end else if (i_paddr == hbp_pkg::ADDR_BRIDGE0 + 8'h08) begin
      rd_data[30:0] = bridge_r[2];
    end else if (i_paddr == hbp_pkg::ADDR_STATUS) begin
      // Regulation flags, then gate states
      rd_data[8:0] = {ls_on, hs_on, in_reg};
    end else if (i_paddr == hbp_pkg::ADDR_IRQ_STAT) begin
      rd_data[5:0] = irq_stat_r;
    end else if (i_paddr == hbp_pkg::ADDR_IRQ_MASK) begin
      rd_data[5:0] = irq_mask_r;
    end else begin
      addr_ok = 1'b0; // Unmapped
    end
  end
  //////////////////////////////////////////////////////////////////
  // APB answer: one access cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= i_psel & ~i_penable;
      o_pslverr <= i_psel & ~i_penable & ~addr_ok;
      if (rd_setup) begin
        o_prdata <= rd_data;
      end else if (i_psel & i_penable & o_pready) begin
        o_prdata <= 32'h0000_0000;
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // Control and window registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      ctrl_r <= hbp_pkg::CTRL_RST;
      win_r <= hbp_pkg::WIN_RST;
    end else if (wr_acc) begin
      if (i_paddr == hbp_pkg::ADDR_CTRL) begin
        ctrl_r <= i_pwdata[4:0];
      end else if (i_paddr == hbp_pkg::ADDR_WIN) begin
        win_r <= i_pwdata[23:0];
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // Per-bridge registers
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      bridge_r <= {3{hbp_pkg::BRIDGE_RST}};
    end else if (wr_acc) begin
      for (int b = 0; b < hbp_pkg::NB; b++) begin
        if (i_paddr == hbp_pkg::ADDR_BRIDGE0 + 8'(b * 4)) begin
          bridge_r[b] <= i_pwdata[30:0];
        end
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // Interrupt mask register
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_mask_r <= 6'h00;
    end else if (wr_acc && i_paddr == hbp_pkg::ADDR_IRQ_MASK) begin
      irq_mask_r <= i_pwdata[5:0];
    end
  end
  //////////////////////////////////////////////////////////////////
  // Sticky status, write one to clear, set wins
  always_comb begin
    irq_set = 6'h00;
    irq_set[hbp_pkg::IRQ_REG_LSB +: 3] = in_reg & ~in_reg_d_r;
    irq_set[hbp_pkg::IRQ_IGN_LSB +: 3] = ign;
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      irq_stat_r <= 6'h00;
      in_reg_d_r <= 3'h0;
      o_irq <= 1'b0;
    end else begin
      in_reg_d_r <= in_reg;
      if (wr_acc && i_paddr == hbp_pkg::ADDR_IRQ_STAT) begin
        irq_stat_r <= (irq_stat_r & ~i_pwdata[5:0]) | irq_set;
      end else begin
        irq_stat_r <= irq_stat_r | irq_set;
      end
      // Level output from the updated status
      o_irq <= |(((irq_stat_r & ~({6{wr_acc && i_paddr == hbp_pkg::ADDR_IRQ_STAT}}
        & i_pwdata[5:0])) | irq_set) & irq_mask_r);
    end
  end
  //////////////////////////////////////////////////////////////////
  // Three-stage pin synchroniser
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      sync1_r <= 6'h00;
      sync2_r <= 6'h00;
      sync3_r <= 6'h00;
    end else begin
      sync1_r <= i_pwm_in;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
    end
  end
  // Level accepted when stages two and three agree
  always_comb begin
    agree = ~(sync2_r ^ sync3_r);
  end
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      pwm_r <= 6'h00;
    end else begin
      pwm_r <= (sync3_r & agree) | (pwm_r & ~agree);
    end
  end
  //////////////////////////////////////////////////////////////////
  // Mode qualification and role selection
  always_comb begin
    adapt_sel = ctrl_r.adaptive_gate_ctrl_sel == hbp_pkg::AGC_ADAPT_A
      || ctrl_r.adaptive_gate_ctrl_sel == hbp_pkg::AGC_ADAPT_B;
    for (int b = 0; b < hbp_pkg::NB; b++) begin
      // Only select=1, enable=1 and mode 01 or 10
      bridge_run[b] = ctrl_r.pwm_input_count_sel
        && bridge_r[b].bridge_pwm_enable
        && (bridge_r[b].bridge_mode_sel == hbp_pkg::MODE_LS_PWM
        || bridge_r[b].bridge_mode_sel == hbp_pkg::MODE_HS_PWM);
      // Detected role, else fixed by mode
      hs_active[b] = ctrl_r.role_detect_enable ? i_hs_active_det[b]
        : (bridge_r[b].bridge_mode_sel == hbp_pkg::MODE_HS_PWM);
      reg_active[b] = adapt_sel && bridge_run[b];
    end
  end
  //////////////////////////////////////////////////////////////////
  // Per-bridge sequencers and regulation trackers
  for (genvar g = 0; g < 3; g++) begin : g_bridge
    // Input pair 2g/2g+1 drives bridge g
    hbp_gate_seq u_seq (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_enable(bridge_run[g]),
      .i_hs_req(pwm_r[2 * g]),
      .i_ls_req(pwm_r[2 * g + 1]),
      .i_hs_active(hs_active[g]),
      .i_win(win_r),
      .o_hs_on(hs_on[g]),
      .o_ls_on(ls_on[g]),
      .o_hard_off(hard[g]),
      .o_ignored(ign[g])
    );
    hbp_delay_reg u_reg (
      .i_clk_sys(i_clk_sys),
      .i_resetn(i_resetn),
      .i_active(reg_active[g]),
      .i_meas(i_meas[g]),
      .i_tgt_on(bridge_r[g].target_turn_on_delay),
      .i_tgt_off(bridge_r[g].target_turn_off_delay),
      .o_in_reg(in_reg[g])
    );
  end
  //////////////////////////////////////////////////////////////////
  // Registered gate and code outputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_hs_on <= 3'h0;
      o_ls_on <= 3'h0;
      o_hard_turn_off <= 3'h0;
      o_passive_off <= 3'h7;
      o_active_off <= 3'h0;
      o_gate_charge_current_code <= {3{hbp_pkg::CODE_MIN}};
      o_initial_precharge_code <= {3{hbp_pkg::CODE_MIN}};
      o_delay_in_regulation_flag <= 3'h0;
    end else begin
      o_hs_on <= hs_on;
      o_ls_on <= ls_on;
      o_hard_turn_off <= hard;
      o_delay_in_regulation_flag <= in_reg;
      for (int b = 0; b < hbp_pkg::NB; b++) begin
        // Held off regardless of enable
        o_passive_off[b] <= bridge_r[b].bridge_mode_sel == hbp_pkg::MODE_PASSIVE_OFF;
        o_active_off[b] <= bridge_r[b].bridge_mode_sel == hbp_pkg::MODE_ACTIVE_OFF;
        // Codes pass unchanged, larger code is larger current
        o_gate_charge_current_code[6 * b +: 6] <=
          bridge_r[b].gate_charge_current_code;
        o_initial_precharge_code[6 * b +: 6] <= bridge_r[b].initial_precharge_code;
      end
    end
  end
endmodule : hbp_top

// File: pkg/hbp_pkg.sv
// Constants, register map and carrier types of the six-input half-bridge PWM control
//
// Overview of operation
// - Bridge 1: inputs 1/2 decode to HS/LS
// - Bridge 2: inputs 3/4 decode likewise
// - Bridge 3: inputs 5/6 decode likewise
// - Early HS edge waits out freewheel window
// - Early LS edge waits out active window
// - HS edge before timeout: hard-off LS, on
// - Freewheel switch fully off before active on
// - Active switch fully off before freewheel on
// - Mode 10 without detection: HS is active
// - One regulation flag per bridge, ADAPTIVE_GATE_CTRL_SEL 10/11
// - Turn-on counter: equal up, differ down
// - Turn-off counter: equal up, differ down
// - Both counters at least 8: in regulation
// - Three consecutive error sign changes: regulation
// - Six-bit current codes, 000000 is smallest
// - Mode 00 passive off, 11 active off
// - Six inputs only with select and enable
// - Mode 01 without detection: LS is active
package hbp_pkg;
  // APB byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_WIN = 8'h04;
  localparam logic [7:0] ADDR_BRIDGE0 = 8'h08;
  localparam logic [7:0] ADDR_BRIDGE_STEP = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h18;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h1c;
  // Bridge modes
  localparam logic [1:0] MODE_PASSIVE_OFF = 2'h0;
  localparam logic [1:0] MODE_LS_PWM = 2'h1;
  localparam logic [1:0] MODE_HS_PWM = 2'h2;
  localparam logic [1:0] MODE_ACTIVE_OFF = 2'h3;
  // Adaptive control settings that use regulation
  localparam logic [1:0] AGC_ADAPT_A = 2'h2;
  localparam logic [1:0] AGC_ADAPT_B = 2'h3;
  // Regulation counters
  localparam int CNT_W = 4;
  localparam logic [3:0] CNT_MAX = 4'hf;
  localparam logic [3:0] CNT_REG_MIN = 4'h8;
  localparam logic [1:0] SIGN_CHG_REG = 2'h3;
  // Smallest current code
  localparam logic [5:0] CODE_MIN = 6'h00;
  // Interrupt status bit positions
  localparam int IRQ_REG_LSB = 0;
  localparam int IRQ_IGN_LSB = 3;
  localparam int IRQ_W = 6;
  localparam int NB = 3;
  // Global control, reset 0
  typedef struct packed {
    logic [1:0] adaptive_gate_ctrl_sel;
    logic role_detect_enable;
    logic postcharge_disable;
    logic pwm_input_count_sel;
  } hbp_ctrl_s;
  // Window lengths in clock cycles, reset 0
  typedef struct packed {
    logic [7:0] toff_timeout_fw;
    logic [7:0] window_fw;
    logic [7:0] window_active;
  } hbp_win_s;
  // Per-bridge settings, reset 0 (mode 00)
  typedef struct packed {
    logic [7:0] target_turn_off_delay;
    logic [7:0] target_turn_on_delay;
    logic [5:0] initial_precharge_code;
    logic [5:0] gate_charge_current_code;
    logic bridge_pwm_enable;
    logic [1:0] bridge_mode_sel;
  } hbp_bridge_s;
  // One measurement per PWM cycle
  typedef struct packed {
    logic valid;
    logic [7:0] turn_on;
    logic [7:0] turn_off;
  } hbp_meas_s;
  localparam hbp_ctrl_s CTRL_RST = '0;
  localparam hbp_win_s WIN_RST = '0;
  localparam hbp_bridge_s BRIDGE_RST = '0;
endpackage : hbp_pkg

// File: hdl/hbp_gate_seq.sv
// Per-bridge gate sequencing with cross-conduction windows
`timescale 1ns/10ps
module hbp_gate_seq (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_enable,
  input wire logic i_hs_req,
  input wire logic i_ls_req,
  input wire logic i_hs_active,
  input wire hbp_pkg::hbp_win_s i_win,
  output logic o_hs_on,
  output logic o_ls_on,
  output logic o_hard_off,
  output logic o_ignored
);
  // Gray coded states
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_DEAD = 2'h1, ST_HS = 2'h3, ST_LS = 2'h2
  } hbp_gate_e;
  hbp_gate_e state_r, state_nxt;
  logic [7:0] cnt_r; // Cycles since last switch-off
  logic last_hs_r; // Switch turned off was HS
  logic dec_hs, dec_ls, other, same, last_act, hard, ign, other_d_r;
  logic [7:0] wait_len;
  //////////////////////////////////////////////////////////////////
  // Decode and next state
  always_comb begin
    dec_hs = i_enable & i_hs_req & ~i_ls_req;
    dec_ls = i_enable & i_ls_req & ~i_hs_req;
    other = last_hs_r ? dec_ls : dec_hs;
    same = last_hs_r ? dec_hs : dec_ls;
    last_act = (last_hs_r == i_hs_active);
    // After active off wait active window, else freewheel window
    wait_len = last_act ? i_win.window_active : i_win.window_fw;
    state_nxt = state_r;
    hard = 1'b0;
    ign = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (dec_hs) begin
          state_nxt = ST_HS;
        end else if (dec_ls) begin
          state_nxt = ST_LS;
        end
      end
      ST_HS: begin
        if (!dec_hs) begin
          state_nxt = ST_DEAD;
        end
      end
      ST_LS: begin
        if (!dec_ls) begin
          state_nxt = ST_DEAD;
        end
      end
      default: begin
        if (other && cnt_r >= wait_len) begin
          state_nxt = last_hs_r ? ST_LS : ST_HS;
          // Freewheel still discharging: hard off
          hard = !last_act && cnt_r < i_win.toff_timeout_fw;
        end else if (other) begin
          ign = !other_d_r;
        end else if (same) begin
          state_nxt = last_hs_r ? ST_HS : ST_LS;
        end else if (cnt_r >= wait_len && cnt_r >= i_win.toff_timeout_fw) begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
    if (!i_enable) begin
      state_nxt = ST_IDLE;
    end
  end
  //////////////////////////////////////////////////////////////////
  // State, counter and registered outputs
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 8'h00;
      last_hs_r <= 1'b0;
      other_d_r <= 1'b0;
      o_hs_on <= 1'b0;
      o_ls_on <= 1'b0;
      o_hard_off <= 1'b0;
      o_ignored <= 1'b0;
    end else begin
      state_r <= state_nxt;
      other_d_r <= other;
      if (state_nxt == ST_DEAD && state_r != ST_DEAD) begin
        cnt_r <= 8'h00;
        last_hs_r <= (state_r == ST_HS);
      end else if (cnt_r != 8'hff) begin
        cnt_r <= cnt_r + 8'h01;
      end
      o_hs_on <= (state_nxt == ST_HS);
      o_ls_on <= (state_nxt == ST_LS);
      o_hard_off <= hard;
      o_ignored <= ign;
    end
  end
endmodule : hbp_gate_seq

// File: hdl/hbp_delay_reg.sv
// Per-bridge turn-on/turn-off delay regulation tracking
`timescale 1ns/10ps
module hbp_delay_reg (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_active,
  input wire hbp_pkg::hbp_meas_s i_meas,
  input wire logic [7:0] i_tgt_on,
  input wire logic [7:0] i_tgt_off,
  output logic o_in_reg
);
  logic [3:0] on_cnt_r, off_cnt_r; // Match counters
  logic [1:0] chg_cnt_r; // Consecutive sign changes
  logic on_neg_r, off_neg_r; // Previous error signs
  logic on_neg, off_neg, flip;
  //////////////////////////////////////////////////////////////////
  // Sign of measured minus target
  always_comb begin
    on_neg = i_meas.turn_on < i_tgt_on;
    off_neg = i_meas.turn_off < i_tgt_off;
    flip = (on_neg != on_neg_r) | (off_neg != off_neg_r);
  end
  //////////////////////////////////////////////////////////////////
  // Counters, once per PWM cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      on_cnt_r <= 4'h0;
      off_cnt_r <= 4'h0;
      chg_cnt_r <= 2'h0;
      on_neg_r <= 1'b0;
      off_neg_r <= 1'b0;
    end else if (!i_active) begin
      on_cnt_r <= 4'h0;
      off_cnt_r <= 4'h0;
      chg_cnt_r <= 2'h0;
    end else if (i_meas.valid) begin
      if (i_meas.turn_on == i_tgt_on) begin
        if (on_cnt_r != hbp_pkg::CNT_MAX) on_cnt_r <= on_cnt_r + 4'h1;
      end else if (on_cnt_r != 4'h0) begin
        on_cnt_r <= on_cnt_r - 4'h1;
      end
      if (i_meas.turn_off == i_tgt_off) begin
        if (off_cnt_r != hbp_pkg::CNT_MAX) off_cnt_r <= off_cnt_r + 4'h1;
      end else if (off_cnt_r != 4'h0) begin
        off_cnt_r <= off_cnt_r - 4'h1;
      end
      on_neg_r <= on_neg;
      off_neg_r <= off_neg;
      if (!flip) begin
        chg_cnt_r <= 2'h0;
      end else if (chg_cnt_r != hbp_pkg::SIGN_CHG_REG) begin
        chg_cnt_r <= chg_cnt_r + 2'h1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////
  // Regulation flag
  always_ff @(posedge i_clk_sys or negedge i_resetn) begin
    if (!i_resetn) begin
      o_in_reg <= 1'b0;
    end else begin
      o_in_reg <= i_active &&
        ((on_cnt_r >= hbp_pkg::CNT_REG_MIN && off_cnt_r >= hbp_pkg::CNT_REG_MIN)
        || chg_cnt_r == hbp_pkg::SIGN_CHG_REG);
    end
  end
endmodule : hbp_delay_reg

// File: tb/hbp_pwm_tmr.sv
// Timer model that drives the six PWM pins
`timescale 1ns/10ps
module hbp_pwm_tmr (
  input wire logic i_clk_sys,
  input wire logic [5:0] i_pattern,
  output logic [5:0] o_pwm_in
);
  // Pins change only on the timer clock, like compare outputs; one driver only
  always @(posedge i_clk_sys) begin
    o_pwm_in <= i_pattern;
  end
endmodule : hbp_pwm_tmr

// File: tb/hbp_checker.sv
// Port-level assertions of the half-bridge PWM control
`timescale 1ns/10ps
module hbp_checker (
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [2:0] o_hs_on,
  input wire logic [2:0] o_ls_on,
  input wire logic [2:0] o_hard_turn_off,
  input wire logic [2:0] o_passive_off,
  input wire logic [2:0] o_active_off
);
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_resetn);
  ////////////////////////////////////////////////////////////////
  // Bus phases
  sequence s_setup;
    i_psel && !i_penable;
  endsequence
  sequence s_access;
    i_psel && i_penable && o_pready;
  endsequence
  AST_PREADY_NEXT: assert property (s_setup |=> s_access)
    else $error("pready missing in access cycle");
  AST_PREADY_ONE: assert property (o_pready |=> !o_pready)
    else $error("pready held too long");
  AST_SLVERR_READY: assert property (o_pslverr |-> o_pready)
    else $error("pslverr without pready");
  ////////////////////////////////////////////////////////////////
  // Gate commands
  AST_NO_SHOOT: assert property ((o_hs_on & o_ls_on) == 3'h0)
    else $error("both switches on");
  AST_HS_GAP: assert property ((o_hs_on & ~$past(o_hs_on) & $past(o_ls_on)) == 3'h0)
    else $error("high side on before low side off");
  AST_LS_GAP: assert property ((o_ls_on & ~$past(o_ls_on) & $past(o_hs_on)) == 3'h0)
    else $error("low side on before high side off");
  AST_HARD_EDGE: assert property ((o_hard_turn_off & ~(o_hs_on & ~$past(o_hs_on))
    & ~(o_ls_on & ~$past(o_ls_on))) == 3'h0)
    else $error("hard off away from turn-on");
  AST_HARD_PULSE: assert property ((o_hard_turn_off & $past(o_hard_turn_off)) == 3'h0)
    else $error("hard off longer than a cycle");
  AST_ACT_OFF: assert property ((o_active_off & $past(o_active_off, 2) & (o_hs_on | o_ls_on))
    == 3'h0)
    else $error("gate on in active off");
  AST_PAS_OFF: assert property ((o_passive_off & $past(o_passive_off, 2) & (o_hs_on | o_ls_on))
    == 3'h0)
    else $error("gate on in passive off");
endmodule : hbp_checker

// File: tb/testbench.sv
// Self-checking bench of the six-input half-bridge PWM control
`timescale 1ns/10ps
module testbench;
  logic i_clk_sys, i_resetn, i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, err, hsa;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [5:0] pat, i_pwm_in;
  logic [2:0] i_hs_active_det, o_hs_on, o_ls_on, o_hard_turn_off, o_passive_off, o_active_off;
  logic [2:0] o_delay_in_regulation_flag;
  logic [17:0] o_gate_charge_current_code, o_initial_precharge_code;
  hbp_pkg::hbp_meas_s [2:0] i_meas;
  int num_errors, checked, gap, n0;
  int nhard = 0;
  // Role cases: mode, detection on, detected high side active
  logic [1:0] md [4] = '{2'h2, 2'h1, 2'h1, 2'h2};
  logic dn [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
  logic dt [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  hbp_pwm_tmr i_tmr (.i_clk_sys, .i_pattern(pat), .o_pwm_in(i_pwm_in));
  hbp_top i_dut (.i_clk_sys, .i_resetn, .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
    .o_prdata, .o_pready, .o_pslverr, .i_pwm_in, .i_hs_active_det, .i_meas, .o_hs_on, .o_ls_on,
    .o_hard_turn_off, .o_passive_off, .o_active_off, .o_gate_charge_current_code,
    .o_initial_precharge_code, .o_delay_in_regulation_flag, .o_irq);
  // 200 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #2.5 i_clk_sys = ~i_clk_sys;
  end
  // Counts hard-off pulses of bridge 0
  always @(posedge i_clk_sys) nhard <= nhard + int'(o_hard_turn_off[0]);
  ////////////////////////////////////////////////////////////////
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(posedge i_clk_sys);
  endtask : cyc
  // One bus transfer; waits for pready under a bound
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_clk_sys);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= w;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_clk_sys);
    i_penable <= 1'b1;
    @(posedge i_clk_sys);
    while (o_pready !== 1'b1 && n < 20) begin
      @(posedge i_clk_sys);
      n++;
    end
    if (n == 20) num_errors++;
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  // Bridge word with targets 5 and 7
  function automatic logic [31:0] bw(input logic [1:0] m, input logic e, input logic [5:0] c,
    input logic [5:0] p);
    return {1'b0, 8'h07, 8'h05, p, c, e, m};
  endfunction : bw
  // Hands bridge 0 to the other switch and times the dead gap
  task swap(input logic to_hs);
    int n;
    n = 0;
    gap = 0;
    pat[1:0] <= to_hs ? 2'h1 : 2'h2;
    while ((to_hs ? o_ls_on[0] : o_hs_on[0]) && n < 60) begin
      @(posedge i_clk_sys);
      n++;
    end
    while (!(to_hs ? o_hs_on[0] : o_ls_on[0]) && n < 60) begin
      @(posedge i_clk_sys);
      n++;
      gap++;
    end
  endtask : swap
  task gchk(input int w);
    chk("gap", 32'h1, 32'(gap >= w - 1 && gap <= w + 2));
  endtask : gchk
  task mp(input logic [7:0] on, input logic [7:0] off);
    i_meas[0] <= {1'b1, on, off};
    @(posedge i_clk_sys);
    i_meas[0].valid <= 1'b0;
  endtask : mp
  task stop_test;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test
  ////////////////////////////////////////////////////////////////
  initial begin
    {i_resetn, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
    pat = 6'h00;
    i_hs_active_det = 3'h0;
    i_meas = '0;
    repeat (10) @(posedge i_clk_sys);
    chk("passive", 32'h7, o_passive_off);
    i_resetn <= 1'b1;
    // Reset values, then the unmapped place
    for (int a = 0; a <= 32; a += 4) begin
      apb(1'b0, 8'(a), 32'h0);
      chk("rst", 32'h0, rd);
      chk("err", 32'(a == 32), err);
    end
    apb(1'b1, hbp_pkg::ADDR_WIN, 32'h001e0a04);
    apb(1'b1, hbp_pkg::ADDR_CTRL, 32'h1);
    for (int b = 0; b < 3; b++) apb(1'b1, 8'(8 + 4 * b), bw(2'h2, 1'b1, 6'(63 - b), 6'(b)));
    cyc(2);
    chk("chg", 32'h0003dfbf, o_gate_charge_current_code);
    chk("pre", 32'h00002040, o_initial_precharge_code);
    $display("registers done");
    for (int b = 0; b < 3; b++) begin
      for (int k = 0; k < 4; k++) begin
        pat[2 * b +: 2] <= 2'(k);
        cyc(40);
        chk("hs", 32'(3'(k == 1) << b), o_hs_on);
        chk("ls", 32'(3'(k == 2) << b), o_ls_on);
      end
    end
    apb(1'b0, hbp_pkg::ADDR_IRQ_STAT, 32'h0);
    chk("stat", 32'h38, rd);
    chk("irq", 32'h0, o_irq);
    apb(1'b1, hbp_pkg::ADDR_IRQ_MASK, 32'h08);
    cyc(2);
    chk("irq", 32'h1, o_irq);
    apb(1'b1, hbp_pkg::ADDR_IRQ_STAT, 32'h38);
    cyc(2);
    chk("irq", 32'h0, o_irq);
    $display("decode done");
    pat <= 6'h15;
    apb(1'b1, 8'h08, bw(2'h2, 1'b0, 6'h3f, 6'h00));
    apb(1'b1, 8'h0c, bw(2'h3, 1'b1, 6'h3f, 6'h00));
    apb(1'b1, 8'h10, bw(2'h0, 1'b1, 6'h3f, 6'h00));
    cyc(40);
    chk("hs", 32'h0, o_hs_on);
    chk("act", 32'h2, o_active_off);
    chk("pas", 32'h4, o_passive_off);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, hbp_pkg::ADDR_CTRL, {29'h0, dn[i], 2'h1});
      apb(1'b1, hbp_pkg::ADDR_BRIDGE0, bw(md[i], 1'b1, 6'h3f, 6'h00));
      i_hs_active_det <= {2'h0, dt[i]};
      pat <= 6'h02;
      cyc(40);
      hsa = dn[i] ? dt[i] : (md[i] == 2'h2);
      n0 = nhard;
      swap(1'b1);
      gchk(hsa ? 10 : 4);
      // Let the pulse counter settle before looking at it
      cyc(1);
      chk("hard", 32'(hsa), 32'(nhard > n0));
      swap(1'b0);
      gchk(hsa ? 4 : 10);
    end
    apb(1'b1, hbp_pkg::ADDR_CTRL, 32'h0);
    cyc(40);
    chk("ls", 32'h0, o_ls_on);
    $display("windows done");
    apb(1'b1, hbp_pkg::ADDR_CTRL, 32'h11);
    for (int k = 0; k < 8; k++) begin
      cyc(3);
      chk("treg", 32'h0, o_delay_in_regulation_flag);
      mp(8'h05, 8'h07);
    end
    cyc(3);
    chk("treg", 32'h1, o_delay_in_regulation_flag);
    apb(1'b1, hbp_pkg::ADDR_CTRL, 32'h1);
    cyc(3);
    chk("treg", 32'h0, o_delay_in_regulation_flag);
    apb(1'b1, hbp_pkg::ADDR_CTRL, 32'h19);
    for (int k = 0; k < 4; k++) begin
      mp(k[0] ? 8'h04 : 8'h06, 8'h07);
      cyc(3);
      chk("treg", 32'(k == 3), o_delay_in_regulation_flag);
    end
    $display("regulation done");
    stop_test;
  end
  // Watchdog well beyond the expected thousand or so cycles
  initial begin
    repeat (20000) @(posedge i_clk_sys);
    num_errors++;
    stop_test;
  end
endmodule : testbench
bind hbp_top hbp_checker u_chk (.i_clk_sys, .i_resetn, .i_psel, .i_penable, .o_pready,
  .o_pslverr, .o_hs_on, .o_ls_on, .o_hard_turn_off, .o_passive_off, .o_active_off);
